// ===== logic/iro_port_regs.vh
// Purpose: constants for the isolated input / relay output port.
// Assumes: byte-wide I/O register access decoded from a host-assigned base.
// Notes: offsets are byte offsets from the base address.
`ifndef IRO_PORT_REGS_VH
`define IRO_PORT_REGS_VH

`define IRO_OFS_RELAY 2'h0
`define IRO_OFS_INPUT 2'h1
`define IRO_OFS_IRQEN 2'h2
`define IRO_OFS_STAT 2'h3
`define IRO_ADDR_W 16
`define IRO_BASE_LSB 2
`define IRO_RELAY_RST 8'h00
`define IRO_STAT_OCC_BIT 0
`define IRO_STAT_EN_BIT 1
`define IRO_STAT_PAD 6'h00
`define IRO_BYTE_ZERO 8'h00
`define IRO_IN_W 8
`define IRO_FILL_ZERO 3'd0
`define IRO_FILL_ONE 3'd1
`define IRO_FILL_CNT 3'd4
// Identification codes: arbitrary neutral values
`define IRO_VENDOR_ID 16'h1234
`define IRO_DEVICE_ID 16'h5678

`endif

// ===== logic/iro_port.v
// Purpose: byte-wide isolated input and relay output port with change interrupt.
// Assumes: single 250 MHz clock; async isolated inputs synchronized here.
// Notes: read data is registered; o_rd_valid marks it one cycle after the strobe.
`timescale 1ns/1ps
`include "iro_port_regs.vh"

module iro_port (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_srst,
  input wire i_ce,
  // Host I/O access
  input wire [15:0] i_base,
  input wire [15:0] i_addr,
  input wire i_rd,
  input wire i_wr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rd_valid,
  // Field side
  input wire [7:0] i_inputs,
  output reg [7:0] o_relay,
  output reg o_irq,
  // Identification
  output reg [15:0] o_vendor_id,
  output reg [15:0] o_device_id
);

  // Input path: pin, three sync stages, agreement filter, accepted byte
  // Interrupt path: accepted change, pending and occurred flags, line
  // Host path: base decode, per-offset strobes, registered read return
  // Hazard: change and clear in one cycle keep the flag set
  // Limitation: changes while disabled are dropped, not queued
  // Startup: first samples after reset never count as a change

  // Synchronizer stages for the isolated inputs
  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [7:0] sync3_reg;

  // Accepted input state and startup fill
  reg [7:0] in_state_reg;
  reg [7:0] in_state_next;
  reg [2:0] fill_reg;
  reg [2:0] fill_next;
  reg seen_reg;
  reg seen_next;

  // Interrupt control state
  reg pend_reg;
  reg pend_next;
  reg en_reg;
  reg en_next;
  reg occ_reg;
  reg occ_next;
  reg irq_next;

  // Relay latch
  reg [7:0] relay_reg;
  reg [7:0] relay_next;

  // Read return path
  reg [7:0] rdata_next;
  reg rd_valid_next;

  // Address decode
  wire hit;
  wire [1:0] ofs;
  wire rd_hit;
  wire wr_hit;
  wire rd_relay;
  wire rd_input;
  wire rd_irqen;
  wire rd_stat;
  wire wr_relay;
  wire wr_input;
  wire wr_irqen;

  // Change detection
  wire [7:0] settled;
  wire [7:0] diff;
  wire change;
  wire raise;

  // Base-relative decode, low bits pick the register
  assign hit = (i_addr[`IRO_ADDR_W-1:`IRO_BASE_LSB] == i_base[`IRO_ADDR_W-1:`IRO_BASE_LSB]);
  assign ofs = i_addr[`IRO_BASE_LSB-1:0];

  // Strobes qualified by a base hit
  assign rd_hit = hit && i_rd;
  assign wr_hit = hit && i_wr;

  // Per-register read strobes
  assign rd_relay = rd_hit && (ofs == `IRO_OFS_RELAY);
  assign rd_input = rd_hit && (ofs == `IRO_OFS_INPUT);
  assign rd_irqen = rd_hit && (ofs == `IRO_OFS_IRQEN);
  assign rd_stat = rd_hit && (ofs == `IRO_OFS_STAT);

  // Per-register write strobes; offset three has none
  assign wr_relay = wr_hit && (ofs == `IRO_OFS_RELAY);
  assign wr_input = wr_hit && (ofs == `IRO_OFS_INPUT);
  assign wr_irqen = wr_hit && (ofs == `IRO_OFS_IRQEN);

  genvar g;
  generate
    for (g = 0; g < `IRO_IN_W; g = g + 1) begin : g_bit
      assign settled[g] = (sync2_reg[g] == sync3_reg[g]) ? sync2_reg[g] : in_state_reg[g];
      assign diff[g] = settled[g] ^ in_state_reg[g];
    end
  endgenerate

  // A change counts once the chain holds real samples
  assign change = seen_reg && (|diff);

  // Changes raise the flags only while enabled
  assign raise = change && en_reg;

  // Startup fill counter
  always @* begin
    fill_next = fill_reg;
    if (fill_reg != `IRO_FILL_CNT) begin
      fill_next = fill_reg + `IRO_FILL_ONE;
    end
    seen_next = (fill_next == `IRO_FILL_CNT);
  end

  // Accepted input byte, bit n is input n
  always @* begin
    in_state_next = settled;
  end

  always @* begin
    en_next = en_reg;
    if (rd_irqen) begin
      en_next = 1'b1;
    end else if (wr_irqen) begin
      en_next = 1'b0;
    end
  end

  // Pending request, set wins over the clear
  always @* begin
    pend_next = pend_reg;
    if (raise) begin
      pend_next = 1'b1;
    end else if (wr_input) begin
      pend_next = 1'b0;
    end
  end

  // Occurred flag, status read clears, set wins
  always @* begin
    occ_next = occ_reg;
    if (raise) begin
      occ_next = 1'b1;
    end else if (rd_stat) begin
      occ_next = 1'b0;
    end
  end

  always @* begin
    irq_next = pend_reg && en_reg;
  end

  always @* begin
    relay_next = relay_reg;
    if (wr_relay) begin
      relay_next = i_wdata;
    end
  end

  // Read data holds until the next read
  always @* begin
    rdata_next = o_rdata;
    rd_valid_next = rd_hit;
    if (rd_relay) begin
      rdata_next = relay_reg;
    end else if (rd_input) begin
      rdata_next = in_state_reg;
    end else if (rd_irqen) begin
      rdata_next = `IRO_BYTE_ZERO;
    end else if (rd_stat) begin
      rdata_next = {`IRO_STAT_PAD, en_reg, occ_reg};
    end
  end

  // Input synchronizer, three stages
  always @(posedge i_clk) begin
    if (i_srst) begin
      sync1_reg <= `IRO_BYTE_ZERO;
      sync2_reg <= `IRO_BYTE_ZERO;
      sync3_reg <= `IRO_BYTE_ZERO;
    end else if (i_ce) begin
      sync1_reg <= i_inputs;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Accepted input state
  always @(posedge i_clk) begin
    if (i_srst) begin
      in_state_reg <= `IRO_BYTE_ZERO;
    end else if (i_ce) begin
      in_state_reg <= in_state_next;
    end
  end

  // Fill tracking after reset
  always @(posedge i_clk) begin
    if (i_srst) begin
      fill_reg <= `IRO_FILL_ZERO;
      seen_reg <= 1'b0;
    end else if (i_ce) begin
      fill_reg <= fill_next;
      seen_reg <= seen_next;
    end
  end

  // Interrupt enable
  always @(posedge i_clk) begin
    if (i_srst) begin
      en_reg <= 1'b0;
    end else if (i_ce) begin
      en_reg <= en_next;
    end
  end

  // Pending request
  always @(posedge i_clk) begin
    if (i_srst) begin
      pend_reg <= 1'b0;
    end else if (i_ce) begin
      pend_reg <= pend_next;
    end
  end

  // Occurred flag
  always @(posedge i_clk) begin
    if (i_srst) begin
      occ_reg <= 1'b0;
    end else if (i_ce) begin
      occ_reg <= occ_next;
    end
  end

  // Relays off at reset; one energizes
  always @(posedge i_clk) begin
    if (i_srst) begin
      relay_reg <= `IRO_RELAY_RST;
      o_relay <= `IRO_RELAY_RST;
    end else if (i_ce) begin
      relay_reg <= relay_next;
      o_relay <= relay_next;
    end
  end

  // Registered interrupt line
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= irq_next;
    end
  end

  // Registered read return
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata <= `IRO_BYTE_ZERO;
      o_rd_valid <= 1'b0;
    end else if (i_ce) begin
      o_rdata <= rdata_next;
      o_rd_valid <= rd_valid_next;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_vendor_id <= `IRO_VENDOR_ID;
      o_device_id <= `IRO_DEVICE_ID;
    end else if (i_ce) begin
      o_vendor_id <= `IRO_VENDOR_ID;
      o_device_id <= `IRO_DEVICE_ID;
    end
  end

endmodule

// ===== bench/iro_port_asserts.sv
// Purpose: port checks; Assumes: ce high; Notes: bound below
`timescale 1ns/1ps
`include "iro_port_regs.vh"
module iro_port_asserts(input wire i_clk, i_srst, i_ce, i_rd, i_wr, o_rd_valid, o_irq,
  input wire [15:0] i_base, i_addr, o_vendor_id, o_device_id,
  input wire [7:0] i_wdata, o_rdata, o_relay, i_inputs);
  wire r = i_ce && i_rd && i_addr[15:2] == i_base[15:2];
  wire w = i_ce && i_wr && i_addr[15:2] == i_base[15:2];
  wire [1:0] f = i_addr[1:0];
  reg [7:0] prev_in = 8'h00;
  reg [2:0] quiet = 3'h0;
  // Cycles since the pins last moved, saturating
  always @(posedge i_clk) begin
    prev_in <= i_inputs;
    quiet <= (i_inputs != prev_in) ? 3'h0 : (quiet == 3'h7) ? quiet : quiet + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence off_s; w && f == 2 ##1 (i_ce && !(r && f == 2)); endsequence
  sequence clr_s; w && f == 1 && quiet == 7 ##1 i_ce; endsequence
  sequence en_s; r && f == 2 ##1 !(w && f == 2) ##1 r && f == 3; endsequence
  chk_relay_load: assert property (w && f == 0 |=> o_relay == $past(i_wdata))
    else $error("load");
  chk_read_valid: assert property (r |=> o_rd_valid) else $error("valid");
  chk_relay_read: assert property (r && f == 0 |=> o_rdata == $past(o_relay))
    else $error("readback");
  chk_status_pad: assert property (r && f == 3 |=> o_rdata[7:2] == 6'h00)
    else $error("pad");
  chk_irq_off: assert property (off_s |=> !o_irq) else $error("off");
  chk_irq_clear: assert property (clr_s |=> !o_irq) else $error("clear");
  chk_stat_enable: assert property (en_s |=> o_rdata[1]) else $error("enable");
  chk_id_fixed: assert property (o_vendor_id == `IRO_VENDOR_ID) else $error("id");
  chk_device_fixed: assert property (o_device_id == `IRO_DEVICE_ID)
    else $error("device");
  chk_reset_idle: assert property ($fell(i_srst) |-> o_relay == 8'h00 && !o_irq)
    else $error("reset");
endmodule
bind iro_port iro_port_asserts chk(.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_rd(i_rd),
  .i_wr(i_wr), .o_rd_valid(o_rd_valid), .o_irq(o_irq), .i_base(i_base), .i_addr(i_addr),
  .o_vendor_id(o_vendor_id), .o_device_id(o_device_id), .i_wdata(i_wdata),
  .o_rdata(o_rdata), .o_relay(o_relay), .i_inputs(i_inputs));

// ===== bench/iro_host.sv
// Purpose: host I/O model; Assumes: fixed base; Notes: released bus inverted
`timescale 1ns/1ps
module iro_host(input wire i_clk, input wire [7:0] i_rdata, output reg o_rd = 0,
  output reg o_wr = 0, output reg [15:0] o_addr = 0, output reg [7:0] o_wdata = 0);
  reg [7:0] q;
  task io(input w, input [1:0] f, input [7:0] d);
    @(posedge i_clk);
    o_rd <= !w; o_wr <= w; o_addr <= 16'h0310 + f; o_wdata <= d;
    @(posedge i_clk);
    o_rd <= 0; o_wr <= 0; o_addr <= ~o_addr; o_wdata <= ~d;
    #1 q = i_rdata;
  endtask
endmodule

// ===== bench/test_isolated_input_relay_output_port.sv
// Purpose: port bench; Assumes: 4 ns clock; Notes: relay model in ints
`timescale 1ns/1ps
module test_isolated_input_relay_output_port;
  reg i_clk = 0, i_srst = 1, i_ce = 1;
  reg [15:0] i_base = 16'h0310;
  reg [7:0] i_inputs = 0;
  wire i_rd, i_wr, o_rd_valid, o_irq;
  wire [15:0] i_addr, o_vendor_id, o_device_id;
  wire [7:0] i_wdata, o_rdata, o_relay;
  integer errors = 0, comparisons = 0, m;
  iro_port dut(.i_clk(i_clk), .i_srst(i_srst), .i_ce(i_ce), .i_base(i_base), .i_addr(i_addr),
    .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rd_valid(o_rd_valid),
    .i_inputs(i_inputs), .o_relay(o_relay), .o_irq(o_irq), .o_vendor_id(o_vendor_id),
    .o_device_id(o_device_id));
  iro_host h(.i_clk(i_clk), .i_rdata(o_rdata), .o_rd(i_rd), .o_wr(i_wr), .o_addr(i_addr),
    .o_wdata(i_wdata));
  initial forever #2 i_clk = ~i_clk;
  task chk(input [7:0] g, e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Toggle one input, then let it settle
  task flip;
    @(posedge i_clk) i_inputs <= i_inputs ^ 8'h01 << $urandom % 8;
    repeat (8) @(posedge i_clk);
    #1;
  endtask
  initial begin #20000; errors++; conclude; end
  initial begin
    m = $urandom(32'hbfc7e5b2);
    repeat (16) @(posedge i_clk);
    i_srst <= 0;
    h.io(0, 0, 0); chk(h.q, 8'h00);
    h.io(0, 3, 0); chk(h.q, 8'h00);
    repeat (6) begin
      m = $urandom;
      h.io(1, 0, m[7:0]); chk(o_relay, m[7:0]);
      h.io(1, 3, ~m[7:0]); h.io(0, 0, 0); chk(h.q, m[7:0]);
    end
    @(posedge i_clk) i_srst <= 1;
    repeat (2) @(posedge i_clk);
    i_srst <= 0;
    h.io(0, 0, 0); chk(h.q, 8'h00);
    i_ce <= 0;
    h.io(1, 0, 8'h3c);
    i_ce <= 1;
    chk(o_relay, 8'h00);
    m = $urandom;
    @(posedge i_clk) i_inputs <= m[7:0];
    repeat (8) @(posedge i_clk);
    h.io(0, 1, 0); chk(h.q, i_inputs);
    h.io(0, 2, 0); h.io(0, 3, 0); chk(h.q, 8'h02);
    flip; chk(o_irq, 1);
    h.io(0, 3, 0); chk(h.q, 8'h03);
    h.io(0, 3, 0); chk(h.q, 8'h02);
    h.io(1, 1, 8'hff); #4 chk(o_irq, 0);
    h.io(1, 2, 8'h5a); h.io(0, 3, 0); chk(h.q, 8'h00);
    flip; chk(o_irq, 0);
    conclude;
  end
endmodule
